//--- fper_pkg.sv
// shared constants and types for the filter, pin and error configuration registers
package fper_pkg;

   // register addresses on the serial register port
   localparam logic [7:0] ADDR_FILTER_TYPE = 8'h1E;
   localparam logic [7:0] ADDR_WIDE_BW = 8'h1F;
   localparam logic [7:0] ADDR_PIN_DIR = 8'h20;
   localparam logic [7:0] ADDR_PIN_DATA = 8'h21;
   localparam logic [7:0] ADDR_ERR_SOURCES = 8'h22;
   localparam logic [7:0] ADDR_ERR_PINS = 8'h23;

   // every addressable register of this block resets to zero; the wideband select flops reset to all ones
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // writable bits; everything else reads as zero except the latched error input status in bit 2 of the error pin register
   localparam logic [7:0] MASK_WIDE_BW = 8'h0F;
   localparam logic [7:0] MASK_ERR_SOURCES = 8'h38;
   localparam logic [7:0] MASK_ERR_PINS_RW = 8'h03;

   // filter type fields, two bits per channel
   localparam int NUM_CH = 4;
   localparam int FILT_W = 2;
   localparam int CH0_LSB = 0;
   localparam int CH1_LSB = 2;
   localparam int CH2_LSB = 4;
   localparam int CH3_LSB = 6;

   // error source enables
   localparam int SRC_OVERRANGE_BIT = 5;
   localparam int SRC_INTERNAL_BIT = 4;
   localparam int SRC_SERIAL_BIT = 3;

   // error pin control bits
   localparam int EPC_OUT_EN_BIT = 0;
   localparam int EPC_IN_EN_BIT = 1;
   localparam int EPC_IN_STATUS_BIT = 2;

   // general pins taken over by the error logic
   localparam int ERR_OUT_PIN = 7;
   localparam int ERR_IN_PIN = 6;

   typedef enum logic [1:0] {
      FPER_FILT_WIDEBAND = 2'b00,
      FPER_FILT_SINC6 = 2'b01,
      FPER_FILT_SINC3 = 2'b10,
      FPER_FILT_SINC3_REJ = 2'b11
   } fper_filter_t;

endpackage : fper_pkg

//--- fper_error_combine.sv
// merges the enabled error sources into one active-high error level
`timescale 1ns/1ns

module fper_error_combine (
   // configuration
   input wire logic [7:0] sources,
   input wire logic [7:0] pin_ctrl,
   input wire logic overrange_monitor_enable,
   // error status from the other units
   input wire logic overrange_error,
   input wire logic internal_error,
   input wire logic serial_error,
   // upstream chain
   input wire logic chain_in,
   // result
   output logic error_level
);

   logic overrange_seen;
   logic chain_seen;

   always_comb begin
      overrange_seen = overrange_error & overrange_monitor_enable;
      chain_seen = chain_in & pin_ctrl[fper_pkg::EPC_IN_EN_BIT];
      error_level = (overrange_seen & sources[fper_pkg::SRC_OVERRANGE_BIT])
                  | (internal_error & sources[fper_pkg::SRC_INTERNAL_BIT])
                  | (serial_error & sources[fper_pkg::SRC_SERIAL_BIT])
                  | chain_seen;
   end

endmodule : fper_error_combine

//--- fper_regs.sv
// filter selection, general pin and error pin configuration registers
`timescale 1ns/1ns

// Operation
// - filter field codes: 00 wideband, 01 sinc6, 10 sinc3, 11 sinc3 with rejection
// - filter fields: ch3 [7:6] down to ch0 [1:0], reset to wideband
// - bandwidth bit clear gives 0.433, set gives 0.10825 times output sample rate
// - bandwidth bit n serves channel n; bits [7:4] reserved, read only
// - direction bit n: 0 input, 1 output for general pin n
// - input pins read their live level; writes to those data bits ignored
// - output pins driven from written data bit, 1 high, 0 low
// - source bit 5 routes analog input overrange errors to the error output
// - source bit 4 routes internal errors to the error output
// - source bit 3 routes serial interface errors to the error output
// - control bit 0 turns the error output pin into the error output
// - control bit 1 accepts the error input pin and ors it in
// - enabled error input status is latched and read in bit 2
// - overrange counts only while the overrange monitor enable is set
module fper_regs (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // filter configuration
   output logic [1:0] filter_type_ch0,
   output logic [1:0] filter_type_ch1,
   output logic [1:0] filter_type_ch2,
   output logic [1:0] filter_type_ch3,
   output logic [3:0] wideband_sel,
   output logic [3:0] sinc6_sel,
   output logic [3:0] sinc3_sel,
   output logic [3:0] sinc3_rej_sel,
   output logic wide_bw_ch0,
   output logic wide_bw_ch1,
   output logic wide_bw_ch2,
   output logic wide_bw_ch3,
   // general pins
   input wire logic [7:0] gpio_in,
   output logic [7:0] gpio_out,
   output logic [7:0] gpio_oe,
   // error status from the other units
   input wire logic overrange_monitor_enable,
   input wire logic overrange_error,
   input wire logic internal_error,
   input wire logic serial_error
);

   logic [7:0] filt_reg, filt_next;
   logic [7:0] bw_reg, bw_next;
   logic [7:0] dir_reg, dir_next;
   logic [7:0] data_reg, data_next;
   logic [7:0] src_reg, src_next;
   logic [7:0] epc_reg, epc_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic [3:0] wb_reg, wb_next;
   logic [3:0] s6_reg, s6_next;
   logic [3:0] s3_reg, s3_next;
   logic [3:0] s3r_reg, s3r_next;
   logic [7:0] pout_reg, pout_next;
   logic [7:0] poe_reg, poe_next;
   logic error_level;
   logic [7:0] pin_readback;

   // one bit per channel whose field holds the given filter code
   function automatic logic [3:0] filter_match(input logic [7:0] sel,
                                               input fper_pkg::fper_filter_t kind);
      logic [3:0] hit;
      hit = 4'h0;
      for (int ch = 0; ch < fper_pkg::NUM_CH; ch++) begin
         hit[ch] = (sel[ch * fper_pkg::FILT_W +: fper_pkg::FILT_W] == kind);
      end
      return hit;
   endfunction : filter_match

   fper_error_combine u_error_combine (
      .sources(src_reg),
      .pin_ctrl(epc_reg),
      .overrange_monitor_enable(overrange_monitor_enable),
      .overrange_error(overrange_error),
      .internal_error(internal_error),
      .serial_error(serial_error),
      .chain_in(gpio_in[fper_pkg::ERR_IN_PIN]),
      .error_level(error_level)
   );

   always_comb begin
      filt_next = filt_reg;
      bw_next = bw_reg;
      dir_next = dir_reg;
      data_next = data_reg;
      src_next = src_reg;
      epc_next = epc_reg;
      rdata_next = fper_pkg::ZERO_BYTE;
      rvalid_next = reg_read;
      // input bits show the pin, output bits the stored value
      pin_readback = (data_reg & dir_reg) | (gpio_in & ~dir_reg);

      if (reg_write) begin
         if (reg_addr == fper_pkg::ADDR_FILTER_TYPE) begin
            filt_next = reg_wdata;
         end else if (reg_addr == fper_pkg::ADDR_WIDE_BW) begin
            bw_next = reg_wdata & fper_pkg::MASK_WIDE_BW;
         end else if (reg_addr == fper_pkg::ADDR_PIN_DIR) begin
            dir_next = reg_wdata;
         end else if (reg_addr == fper_pkg::ADDR_PIN_DATA) begin
            // input bits keep their old value
            data_next = (data_reg & ~dir_reg) | (reg_wdata & dir_reg);
         end else if (reg_addr == fper_pkg::ADDR_ERR_SOURCES) begin
            src_next = reg_wdata & fper_pkg::MASK_ERR_SOURCES;
         end else if (reg_addr == fper_pkg::ADDR_ERR_PINS) begin
            epc_next = (reg_wdata & fper_pkg::MASK_ERR_PINS_RW)
                     | (epc_reg & ~fper_pkg::MASK_ERR_PINS_RW);
         end
      end

      // status clears on a read of the control register; a new event wins
      if (reg_read && reg_addr == fper_pkg::ADDR_ERR_PINS) begin
         epc_next[fper_pkg::EPC_IN_STATUS_BIT] = 1'b0;
      end
      if (epc_reg[fper_pkg::EPC_IN_EN_BIT] && gpio_in[fper_pkg::ERR_IN_PIN]) begin
         epc_next[fper_pkg::EPC_IN_STATUS_BIT] = 1'b1;
      end

      if (reg_read) begin
         if (reg_addr == fper_pkg::ADDR_FILTER_TYPE) begin
            rdata_next = filt_reg;
         end else if (reg_addr == fper_pkg::ADDR_WIDE_BW) begin
            rdata_next = bw_reg;
         end else if (reg_addr == fper_pkg::ADDR_PIN_DIR) begin
            rdata_next = dir_reg;
         end else if (reg_addr == fper_pkg::ADDR_PIN_DATA) begin
            rdata_next = pin_readback;
         end else if (reg_addr == fper_pkg::ADDR_ERR_SOURCES) begin
            rdata_next = src_reg;
         end else if (reg_addr == fper_pkg::ADDR_ERR_PINS) begin
            rdata_next = epc_reg;
         end
      end

      wb_next = filter_match(filt_next, fper_pkg::FPER_FILT_WIDEBAND);
      s6_next = filter_match(filt_next, fper_pkg::FPER_FILT_SINC6);
      s3_next = filter_match(filt_next, fper_pkg::FPER_FILT_SINC3);
      s3r_next = filter_match(filt_next, fper_pkg::FPER_FILT_SINC3_REJ);

      poe_next = dir_reg;
      pout_next = data_reg & dir_reg;
      // the error input pin must not fight the upstream driver
      if (epc_reg[fper_pkg::EPC_IN_EN_BIT]) begin
         poe_next[fper_pkg::ERR_IN_PIN] = 1'b0;
         pout_next[fper_pkg::ERR_IN_PIN] = 1'b0;
      end
      // error output takes over its pin
      if (epc_reg[fper_pkg::EPC_OUT_EN_BIT]) begin
         poe_next[fper_pkg::ERR_OUT_PIN] = 1'b1;
         pout_next[fper_pkg::ERR_OUT_PIN] = error_level;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_reg <= fper_pkg::RESET_VALUE;
         bw_reg <= fper_pkg::RESET_VALUE;
         dir_reg <= fper_pkg::RESET_VALUE;
         data_reg <= fper_pkg::RESET_VALUE;
         src_reg <= fper_pkg::RESET_VALUE;
         epc_reg <= fper_pkg::RESET_VALUE;
         rdata_reg <= fper_pkg::ZERO_BYTE;
         rvalid_reg <= 1'b0;
         wb_reg <= {fper_pkg::NUM_CH{1'b1}};
         s6_reg <= 4'h0;
         s3_reg <= 4'h0;
         s3r_reg <= 4'h0;
         pout_reg <= fper_pkg::ZERO_BYTE;
         poe_reg <= fper_pkg::ZERO_BYTE;
      end else begin
         filt_reg <= filt_next;
         bw_reg <= bw_next;
         dir_reg <= dir_next;
         data_reg <= data_next;
         src_reg <= src_next;
         epc_reg <= epc_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         wb_reg <= wb_next;
         s6_reg <= s6_next;
         s3_reg <= s3_next;
         s3r_reg <= s3r_next;
         pout_reg <= pout_next;
         poe_reg <= poe_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;
   assign filter_type_ch0 = filt_reg[fper_pkg::CH0_LSB +: fper_pkg::FILT_W];
   assign filter_type_ch1 = filt_reg[fper_pkg::CH1_LSB +: fper_pkg::FILT_W];
   assign filter_type_ch2 = filt_reg[fper_pkg::CH2_LSB +: fper_pkg::FILT_W];
   assign filter_type_ch3 = filt_reg[fper_pkg::CH3_LSB +: fper_pkg::FILT_W];
   assign wideband_sel = wb_reg;
   assign sinc6_sel = s6_reg;
   assign sinc3_sel = s3_reg;
   assign sinc3_rej_sel = s3r_reg;
   // set bit selects the narrow wideband bandwidth
   assign wide_bw_ch0 = bw_reg[0];
   assign wide_bw_ch1 = bw_reg[1];
   assign wide_bw_ch2 = bw_reg[2];
   assign wide_bw_ch3 = bw_reg[3];
   assign gpio_out = pout_reg;
   assign gpio_oe = poe_reg;

   property p_filter_decode;
      @(posedge clk) disable iff (!rst_n)
         (wideband_sel[3] == (filter_type_ch3 == 2'b00))
         && (sinc6_sel[1] == (filter_type_ch1 == 2'b01))
         && (sinc3_sel[2] == (filter_type_ch2 == 2'b10))
         && (sinc3_rej_sel[0] == (filter_type_ch0 == 2'b11));
   endproperty
   a_filter_decode: assert property (p_filter_decode) else $error("filter decode wrong");

   property p_filter_write;
      @(posedge clk) disable iff (!rst_n)
         (reg_write && reg_addr == fper_pkg::ADDR_FILTER_TYPE)
         |=> (filter_type_ch3 == $past(reg_wdata[7:6]))
             && (filter_type_ch0 == $past(reg_wdata[1:0]));
   endproperty
   a_filter_write: assert property (p_filter_write) else $error("filter field misplaced");

   property p_bw_write;
      @(posedge clk) disable iff (!rst_n)
         (reg_write && reg_addr == fper_pkg::ADDR_WIDE_BW)
         |=> (wide_bw_ch3 == $past(reg_wdata[3])) && (wide_bw_ch0 == $past(reg_wdata[0]));
   endproperty
   a_bw_write: assert property (p_bw_write) else $error("bandwidth bit misplaced");

   property p_reserved_zero;
      @(posedge clk) disable iff (!rst_n)
         (reg_read && (reg_addr == fper_pkg::ADDR_WIDE_BW || reg_addr == fper_pkg::ADDR_ERR_SOURCES))
         |=> (reg_rdata[7:6] == 2'b00) && (reg_rdata[2:0] == 3'b000 || reg_rdata[7:4] == 4'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

   property p_pin_dir;
      @(posedge clk) disable iff (!rst_n)
         ##1 gpio_oe[0] == $past(dir_reg[0]);
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("pin direction not followed");

   property p_input_read;
      @(posedge clk) disable iff (!rst_n)
         (reg_read && reg_addr == fper_pkg::ADDR_PIN_DATA && !dir_reg[0])
         |=> reg_rdata[0] == $past(gpio_in[0]);
   endproperty
   a_input_read: assert property (p_input_read) else $error("input pin level not read");

   property p_output_drive;
      @(posedge clk) disable iff (!rst_n)
         (reg_write && reg_addr == fper_pkg::ADDR_PIN_DATA && dir_reg[1] && !reg_read)
         |=> ##1 gpio_out[1] == $past(reg_wdata[1], 2);
   endproperty
   a_output_drive: assert property (p_output_drive) else $error("output pin level wrong");

   property p_overrange_route;
      @(posedge clk) disable iff (!rst_n)
         (epc_reg[0] && src_reg[5] && overrange_error && overrange_monitor_enable)
         |=> gpio_out[7] && gpio_oe[7];
   endproperty
   a_overrange_route: assert property (p_overrange_route) else $error("overrange not reported");

   property p_internal_route;
      @(posedge clk) disable iff (!rst_n)
         (epc_reg[0] && src_reg[4] && internal_error) |=> gpio_out[7];
   endproperty
   a_internal_route: assert property (p_internal_route) else $error("internal error lost");

   property p_serial_route;
      @(posedge clk) disable iff (!rst_n)
         (epc_reg[0] && src_reg[3] && serial_error) |=> gpio_out[7];
   endproperty
   a_serial_route: assert property (p_serial_route) else $error("serial error lost");

   property p_quiet_output;
      @(posedge clk) disable iff (!rst_n)
         (epc_reg[0] && !epc_reg[1] && !(src_reg[5] && overrange_error && overrange_monitor_enable)
          && !(src_reg[4] && internal_error) && !(src_reg[3] && serial_error))
         |=> !gpio_out[7];
   endproperty
   a_quiet_output: assert property (p_quiet_output) else $error("error output without cause");

   property p_monitor_gate;
      @(posedge clk) disable iff (!rst_n)
         (epc_reg[0] && src_reg == 8'h20 && !epc_reg[1] && !overrange_monitor_enable)
         |=> !gpio_out[7];
   endproperty
   a_monitor_gate: assert property (p_monitor_gate) else $error("overrange passed unmonitored");

   property p_chain_in;
      @(posedge clk) disable iff (!rst_n)
         (epc_reg[0] && epc_reg[1] && gpio_in[6]) |=> gpio_out[7] && epc_reg[2];
   endproperty
   a_chain_in: assert property (p_chain_in) else $error("chained error not ored or latched");

   property p_status_hold;
      @(posedge clk) disable iff (!rst_n)
         (epc_reg[2] && !(reg_read && reg_addr == fper_pkg::ADDR_ERR_PINS)) |=> epc_reg[2];
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("latched status dropped");

   property p_out_disabled;
      @(posedge clk) disable iff (!rst_n)
         !epc_reg[0] |=> gpio_oe[7] == $past(dir_reg[7]);
   endproperty
   a_out_disabled: assert property (p_out_disabled) else $error("error pin taken while off");

endmodule : fper_regs

//--- fper_pin_partner.sv
// pin-side partner: resolves each general pin from the block drive or the far-end level
`timescale 1ns/1ns

module fper_pin_partner (
   // clock
   input wire logic clk,
   // block side
   input wire logic [7:0] gpio_out,
   input wire logic [7:0] gpio_oe,
   output logic [7:0] gpio_in,
   // far-end drivers, one enable per pin
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_level
);
   logic flip = 1'b0;

   // an unheld pin wanders so that a stale level never reads as a match
   always @(posedge clk) begin
      flip <= ~flip;
   end

   // block drive wins, else far end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (gpio_oe[i]) begin
            gpio_in[i] = gpio_out[i];
         end else if (ext_en[i]) begin
            gpio_in[i] = ext_level[i];
         end else begin
            gpio_in[i] = flip ^ i[0];
         end
      end
   end
endmodule : fper_pin_partner

//--- filter_pin_error_config_regs_tb_top.sv
// self-checking testbench for the filter, pin and error configuration registers
`timescale 1ns/1ns

module filter_pin_error_config_regs_tb_top;
   logic clk, rst_n, reg_write, reg_read, reg_rvalid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, gpio_in, gpio_out, gpio_oe, ext_en, ext_level, d;
   logic [1:0] filter_type_ch0, filter_type_ch1, filter_type_ch2, filter_type_ch3;
   logic [3:0] wideband_sel, sinc6_sel, sinc3_sel, sinc3_rej_sel;
   logic wide_bw_ch0, wide_bw_ch1, wide_bw_ch2, wide_bw_ch3;
   logic overrange_monitor_enable, overrange_error, internal_error, serial_error;
   int error_cnt = 0;
   int check_count = 0;

   fper_regs dut (.clk(clk), .rst_n(rst_n), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .filter_type_ch0(filter_type_ch0),
      .filter_type_ch1(filter_type_ch1), .filter_type_ch2(filter_type_ch2),
      .filter_type_ch3(filter_type_ch3), .wideband_sel(wideband_sel), .sinc6_sel(sinc6_sel),
      .sinc3_sel(sinc3_sel), .sinc3_rej_sel(sinc3_rej_sel), .wide_bw_ch0(wide_bw_ch0),
      .wide_bw_ch1(wide_bw_ch1), .wide_bw_ch2(wide_bw_ch2), .wide_bw_ch3(wide_bw_ch3),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .overrange_monitor_enable(overrange_monitor_enable), .overrange_error(overrange_error),
      .internal_error(internal_error), .serial_error(serial_error));

   fper_pin_partner pins (.clk(clk), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .gpio_in(gpio_in), .ext_en(ext_en), .ext_level(ext_level));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      #1 reg_write = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(posedge clk);
      #1 reg_write = 1'b0;
   endtask : wr

   // the answer stands for one cycle only, so it is taken right after its edge
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      #1 reg_read = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1 reg_read = 1'b0;
      check("read_valid", {7'h00, reg_rvalid}, 8'h01);
      v = reg_rdata;
   endtask : rd

   task automatic t_reset();
      for (int a = 8'h1E; a <= 8'h24; a++) begin
         rd(8'(a), d);
         check("reset_or_unmapped", d, fper_pkg::RESET_VALUE);
      end
      wr(8'h24, 8'hFF);
      rd(8'h24, d);
      check("unmapped_write", d, fper_pkg::ZERO_BYTE);
      check("reset_wideband", {wideband_sel, sinc6_sel}, 8'hF0);
      check("reset_pins_oe", gpio_oe, 8'h00);
   endtask : t_reset

   // a reset in mid-run must bring every mapped register back to zero and the wideband selects back to all ones
   task automatic t_midreset();
      wr(fper_pkg::ADDR_FILTER_TYPE, 8'hE4);
      wr(fper_pkg::ADDR_PIN_DIR, 8'hFF);
      wr(fper_pkg::ADDR_ERR_PINS, 8'h03);
      rst_n = 1'b0;
      cyc(2);
      check("midreset_oe", gpio_oe, 8'h00);
      rst_n = 1'b1;
      for (int a = 8'h1E; a <= 8'h23; a++) begin
         rd(8'(a), d);
         check("midreset_regs", d, fper_pkg::RESET_VALUE);
      end
      check("midreset_wideband", {wideband_sel, sinc6_sel}, 8'hF0);
   endtask : t_midreset

   task automatic t_filter();
      logic [7:0] v;
      logic [1:0] code;
      logic [3:0] wb, s6, s3, sr;
      for (int k = 0; k < 4; k++) begin
         for (int c = 0; c < 4; c++) begin
            code = 2'((c + k) % 4);
            v[2 * c +: 2] = code;
            wb[c] = (code == 2'b00);
            s6[c] = (code == 2'b01);
            s3[c] = (code == 2'b10);
            sr[c] = (code == 2'b11);
         end
         wr(fper_pkg::ADDR_FILTER_TYPE, v);
         cyc(2);
         check("filter_fields", {filter_type_ch3, filter_type_ch2, filter_type_ch1,
            filter_type_ch0}, v);
         check("wide_sinc6", {wideband_sel, sinc6_sel}, {wb, s6});
         check("sinc3_rej", {sinc3_sel, sinc3_rej_sel}, {s3, sr});
         rd(fper_pkg::ADDR_FILTER_TYPE, d);
         check("filter_read", d, v);
      end
   endtask : t_filter

   task automatic t_bw();
      wr(fper_pkg::ADDR_WIDE_BW, 8'hFA);
      cyc(2);
      check("bw_bits", {4'h0, wide_bw_ch3, wide_bw_ch2, wide_bw_ch1, wide_bw_ch0}, 8'h0A);
      rd(fper_pkg::ADDR_WIDE_BW, d);
      check("bw_read", d, 8'h0A);
   endtask : t_bw

   task automatic t_gpio();
      ext_en = 8'hF0;
      ext_level = 8'hA0;
      wr(fper_pkg::ADDR_PIN_DIR, 8'h0F);
      wr(fper_pkg::ADDR_PIN_DATA, 8'hFF);
      cyc(3);
      check("pin_oe", gpio_oe, 8'h0F);
      check("pin_drive", gpio_out & 8'h0F, 8'h0F);
      rd(fper_pkg::ADDR_PIN_DATA, d);
      check("pin_mixed_read", d, 8'hAF);
      ext_level = 8'h50;
      cyc(3);
      rd(fper_pkg::ADDR_PIN_DATA, d);
      check("pin_live_read", d, 8'h5F);
      wr(fper_pkg::ADDR_PIN_DIR, 8'hFF);
      cyc(3);
      rd(fper_pkg::ADDR_PIN_DATA, d);
      check("pin_ignored_write", d, 8'h0F);
      wr(fper_pkg::ADDR_PIN_DATA, 8'h81);
      cyc(3);
      check("pin_out_level", gpio_out, 8'h81);
      ext_en = 8'hFF;
      ext_level = 8'h00;
      wr(fper_pkg::ADDR_PIN_DIR, 8'h00);
   endtask : t_gpio

   task automatic t_err();
      wr(fper_pkg::ADDR_ERR_SOURCES, 8'hFF);
      rd(fper_pkg::ADDR_ERR_SOURCES, d);
      check("src_read", d, 8'h38);
      wr(fper_pkg::ADDR_ERR_PINS, 8'hFD);
      rd(fper_pkg::ADDR_ERR_PINS, d);
      check("epc_read", d, 8'h01);
      cyc(3);
      check("err_pin_oe", {7'h00, gpio_oe[7]}, 8'h01);
      // host has enabled the overrange monitor
      overrange_monitor_enable = 1'b1;
      for (int j = 0; j < 3; j++) begin
         wr(fper_pkg::ADDR_ERR_SOURCES, 8'h20 >> j);
         {overrange_error, internal_error, serial_error} = 3'b100 >> j;
         cyc(3);
         check("err_enabled", {7'h00, gpio_out[7]}, 8'h01);
         wr(fper_pkg::ADDR_ERR_SOURCES, 8'h00);
         cyc(3);
         check("err_masked", {7'h00, gpio_out[7]}, 8'h00);
         {overrange_error, internal_error, serial_error} = 3'b000;
      end
      overrange_monitor_enable = 1'b0;
      overrange_error = 1'b1;
      wr(fper_pkg::ADDR_ERR_SOURCES, 8'h20);
      cyc(3);
      check("overrange_unmonitored", {7'h00, gpio_out[7]}, 8'h00);
      overrange_error = 1'b0;
      wr(fper_pkg::ADDR_ERR_PINS, 8'h03);
      ext_level[6] = 1'b1;
      cyc(3);
      check("chain_in", {6'h00, gpio_oe[6], gpio_out[7]}, 8'h01);
      ext_level[6] = 1'b0;
      cyc(3);
      check("chain_idle", {7'h00, gpio_out[7]}, 8'h00);
      rd(fper_pkg::ADDR_ERR_PINS, d);
      check("chain_status", d, 8'h07);
      rd(fper_pkg::ADDR_ERR_PINS, d);
      check("chain_status_clr", d, 8'h03);
      wr(fper_pkg::ADDR_ERR_PINS, 8'h00);
      cyc(3);
      check("err_pin_released", {7'h00, gpio_oe[7]}, 8'h00);
   endtask : t_err

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   initial begin
      rst_n = 1'b0;
      {reg_write, reg_read, reg_addr, reg_wdata} = 18'h00000;
      {overrange_monitor_enable, overrange_error, internal_error, serial_error} = 4'h0;
      ext_en = 8'hFF;
      ext_level = 8'h00;
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      t_reset();
      t_filter();
      t_bw();
      t_gpio();
      t_err();
      t_midreset();
      summarize();
   end

   // the whole sequence needs under two hundred cycles
   initial begin
      #200000;
      error_cnt++;
      summarize();
   end
endmodule : filter_pin_error_config_regs_tb_top
